// ---- hdl/bmx_matrix.sv ----
// Operation
// - One fixed address map always, boot included; no region remapped.
// - 32-bit space: SRAM at 0x0000_0000 (64K or 32K), flash at 0x8000_0000.
// - With external bus, 16M chip selects at 0xC000, 0xC800, 0xCC00_0000.
// - With external bus, shared 128M window at 0xD000_0000 to external bus.
// - 64K USB configuration window at 0xE000_0000 to USB dual-port memory.
// - First peripheral bridge owns the 64K window at 0xFFFE_0000.
// - Second peripheral bridge owns the 64K window at 0xFFFF_0000.
// - Accesses to unmapped addresses complete with an error response.
// - Each master has its own port and decoder; mapping may differ.
// - Masters 0..5: CPU data, instruction, system access, DMAs.
// - Each slave has its own arbiter with its own policy.
// - Slaves 0..5: flash, bridge A, bridge B, SRAM, USB memory, external.
`include "bmx_defs.svh"

module bmx_matrix (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_ext_bus_en,
  input wire logic i_sram_64k,
  input wire bmx_pkg::bmx_mreq_t [5:0] i_m_req,
  output bmx_pkg::bmx_rsp_t [5:0] o_m_rsp,
  output bmx_pkg::bmx_sreq_t [5:0] o_s_req,
  input wire bmx_pkg::bmx_rsp_t [5:0] i_s_rsp
);

  // ----------------------------------------------------------------
  // Per-master decoders
  // ----------------------------------------------------------------
  localparam logic [35:0] MST_SLAVES = {
    `BMX_MST5_SLAVES, `BMX_MST4_SLAVES, `BMX_MST3_SLAVES,
    `BMX_MST2_SLAVES, `BMX_MST1_SLAVES, `BMX_MST0_SLAVES
  };

  localparam logic [5:0] ARB_RR = `BMX_ARB_ROUND_ROBIN;

  logic [5:0] hit;
  logic [2:0] sel [6];

  // Map is built from constants and the ext bus and SRAM size straps only: nothing can move a window.
  for (genvar m = 0; m < `BMX_NUM_MASTERS; m++) begin : g_dec
    bmx_decoder #(
      .SLAVE_MASK(MST_SLAVES[6*m +: 6])
    ) u_dec (
      .i_addr(i_m_req[m].addr),
      .i_ext_bus_en(i_ext_bus_en),
      .i_sram_64k(i_sram_64k),
      .o_hit(hit[m]),
      .o_slave(sel[m])
    );
  end

  // ----------------------------------------------------------------
  // Default error slave
  // ----------------------------------------------------------------
  // Answers one cycle after an unmapped request; the gap stops a
  // held request from being answered in two cycles running.
  logic [5:0] err_r;
  logic [5:0] err_nxt;

  always_comb begin
    for (int m = 0; m < `BMX_NUM_MASTERS; m++) begin
      err_nxt[m] = i_m_req[m].valid && !hit[m] && !err_r[m];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      err_r <= 6'h00;
    end else begin
      err_r <= err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Per-slave arbiters
  // ----------------------------------------------------------------
  bmx_pkg::bmx_arb_state_t state_r [6];
  logic [2:0] owner_r [6];
  logic [2:0] last_r [6];

  for (genvar s = 0; s < `BMX_NUM_SLAVES; s++) begin : g_arb
    localparam logic RR = ARB_RR[s];
    bmx_pkg::bmx_arb_state_t state_nxt;
    logic [2:0] owner_nxt;
    logic [2:0] last_nxt;
    logic [5:0] want;
    logic found;
    logic [2:0] pick;

    always_comb begin
      want = 6'h00;
      for (int m = 0; m < `BMX_NUM_MASTERS; m++) begin
        want[m] = i_m_req[m].valid && hit[m] && (sel[m] == 3'(s));
      end
      found = 1'b0;
      pick = 3'h0;
      if (RR) begin
        // Search starts after the last winner, so none is starved
        for (int i = 1; i <= `BMX_NUM_MASTERS; i++) begin
          if (!found && want[(int'(last_r[s]) + i) % 6]) begin
            found = 1'b1;
            pick = 3'((int'(last_r[s]) + i) % 6);
          end
        end
      end else begin
        // Fixed priority: lowest master number wins
        for (int m = `BMX_NUM_MASTERS - 1; m >= 0; m--) begin
          if (want[m]) begin
            found = 1'b1;
            pick = 3'(m);
          end
        end
      end
      state_nxt = state_r[s];
      owner_nxt = owner_r[s];
      last_nxt = last_r[s];
      case (state_r[s])
        bmx_pkg::BMX_ARB_IDLE: begin
          if (found) begin
            state_nxt = bmx_pkg::BMX_ARB_BUSY;
            owner_nxt = pick;
            last_nxt = pick;
          end
        end
        bmx_pkg::BMX_ARB_BUSY: begin
          // Grant holds until the slave completes, or the owner gives up
          if (i_s_rsp[s].done || !i_m_req[owner_r[s]].valid) begin
            state_nxt = bmx_pkg::BMX_ARB_IDLE;
          end
        end
        default: begin
          state_nxt = bmx_pkg::BMX_ARB_IDLE;
        end
      endcase
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        state_r[s] <= bmx_pkg::BMX_ARB_IDLE;
        owner_r[s] <= 3'h0;
        last_r[s] <= 3'h5;
      end else begin
        state_r[s] <= state_nxt;
        owner_r[s] <= owner_nxt;
        last_r[s] <= last_nxt;
      end
    end

    always_comb begin
      o_s_req[s].valid = (state_r[s] == bmx_pkg::BMX_ARB_BUSY) &&
                         i_m_req[owner_r[s]].valid;
      o_s_req[s].write = i_m_req[owner_r[s]].write;
      o_s_req[s].master = owner_r[s];
      o_s_req[s].addr = i_m_req[owner_r[s]].addr;
      o_s_req[s].wdata = i_m_req[owner_r[s]].wdata;
    end
  end

  // ----------------------------------------------------------------
  // Response return to masters
  // ----------------------------------------------------------------
  always_comb begin
    for (int m = 0; m < `BMX_NUM_MASTERS; m++) begin
      o_m_rsp[m].done = err_r[m];
      o_m_rsp[m].err = err_r[m];
      o_m_rsp[m].rdata = `BMX_ERR_RDATA;
      for (int s = 0; s < `BMX_NUM_SLAVES; s++) begin
        if (state_r[s] == bmx_pkg::BMX_ARB_BUSY &&
            owner_r[s] == 3'(m) && i_s_rsp[s].done) begin
          o_m_rsp[m].done = 1'b1;
          o_m_rsp[m].err = i_s_rsp[s].err;
          o_m_rsp[m].rdata = i_s_rsp[s].rdata;
        end
      end
    end
  end

endmodule : bmx_matrix

// ---- hdl/bmx_defs.svh ----
`ifndef BMX_DEFS_SVH
`define BMX_DEFS_SVH

// ----------------------------------------------------------------
// Matrix size
// ----------------------------------------------------------------
`define BMX_NUM_MASTERS 6
`define BMX_NUM_SLAVES 6

// ----------------------------------------------------------------
// Master numbers
// ----------------------------------------------------------------
`define BMX_MST_CPU_DATA 3'h0
`define BMX_MST_CPU_INSTR 3'h1
`define BMX_MST_SYS_ACCESS 3'h2
`define BMX_MST_PERIPH_DMA 3'h3
`define BMX_MST_ETH_DMA 3'h4
`define BMX_MST_USB_DMA 3'h5

// ----------------------------------------------------------------
// Slave numbers
// ----------------------------------------------------------------
`define BMX_SLV_FLASH 3'h0
`define BMX_SLV_BRIDGE_A 3'h1
`define BMX_SLV_BRIDGE_B 3'h2
`define BMX_SLV_SRAM 3'h3
`define BMX_SLV_USB_DPRAM 3'h4
`define BMX_SLV_EXT_BUS 3'h5

// ----------------------------------------------------------------
// Address map: base and match mask of each window
// ----------------------------------------------------------------
`define BMX_SRAM_BASE 32'h0000_0000
`define BMX_SRAM_MASK_64K 32'hffff_0000
`define BMX_SRAM_MASK_32K 32'hffff_8000
`define BMX_FLASH_BASE 32'h8000_0000
`define BMX_FLASH_MASK 32'hfff8_0000
`define BMX_EXT_CS0_BASE 32'hc000_0000
`define BMX_EXT_CS2_BASE 32'hc800_0000
`define BMX_EXT_CS3_BASE 32'hcc00_0000
`define BMX_EXT_16M_MASK 32'hff00_0000
`define BMX_EXT_SHARED_BASE 32'hd000_0000
`define BMX_EXT_SHARED_MASK 32'hf800_0000
`define BMX_USB_BASE 32'he000_0000
`define BMX_BRIDGE_A_BASE 32'hfffe_0000
`define BMX_BRIDGE_B_BASE 32'hffff_0000
`define BMX_64K_MASK 32'hffff_0000

// ----------------------------------------------------------------
// Per-master reachable slaves (bit n = slave n), per-slave policy
// ----------------------------------------------------------------
`define BMX_MST0_SLAVES 6'h3f
`define BMX_MST1_SLAVES 6'h3f
`define BMX_MST2_SLAVES 6'h3f
`define BMX_MST3_SLAVES 6'h3f
`define BMX_MST4_SLAVES 6'h3f
`define BMX_MST5_SLAVES 6'h3f
// Bit n set: slave n arbitrates round robin, else fixed priority
`define BMX_ARB_ROUND_ROBIN 6'h3f
`define BMX_ERR_RDATA 32'h0000_0000

`endif

// ---- hdl/bmx_pkg.sv ----
package bmx_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bmx_mreq_t;

  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } bmx_rsp_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] master;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bmx_sreq_t;

  typedef enum logic {
    BMX_ARB_IDLE,
    BMX_ARB_BUSY
  } bmx_arb_state_t;

endpackage : bmx_pkg

// ---- hdl/bmx_decoder.sv ----
`include "bmx_defs.svh"

module bmx_decoder #(
  parameter logic [5:0] SLAVE_MASK = 6'h3f
) (
  input wire logic [31:0] i_addr,
  input wire logic i_ext_bus_en,
  input wire logic i_sram_64k,
  output logic o_hit,
  output logic [2:0] o_slave
);

  logic [31:0] sram_mask;
  logic hit_raw;

  always_comb begin
    sram_mask = i_sram_64k ? `BMX_SRAM_MASK_64K : `BMX_SRAM_MASK_32K;
    hit_raw = 1'b1;
    o_slave = `BMX_SLV_FLASH;
    if ((i_addr & sram_mask) == `BMX_SRAM_BASE) begin
      o_slave = `BMX_SLV_SRAM;
    end else if ((i_addr & `BMX_FLASH_MASK) == `BMX_FLASH_BASE) begin
      o_slave = `BMX_SLV_FLASH;
    end else if (i_ext_bus_en &&
        (((i_addr & `BMX_EXT_16M_MASK) == `BMX_EXT_CS0_BASE) ||
         ((i_addr & `BMX_EXT_16M_MASK) == `BMX_EXT_CS2_BASE) ||
         ((i_addr & `BMX_EXT_16M_MASK) == `BMX_EXT_CS3_BASE))) begin
      o_slave = `BMX_SLV_EXT_BUS;
    end else if (i_ext_bus_en &&
        ((i_addr & `BMX_EXT_SHARED_MASK) == `BMX_EXT_SHARED_BASE)) begin
      o_slave = `BMX_SLV_EXT_BUS;
    end else if ((i_addr & `BMX_64K_MASK) == `BMX_USB_BASE) begin
      o_slave = `BMX_SLV_USB_DPRAM;
    end else if ((i_addr & `BMX_64K_MASK) == `BMX_BRIDGE_A_BASE) begin
      o_slave = `BMX_SLV_BRIDGE_A;
    end else if ((i_addr & `BMX_64K_MASK) == `BMX_BRIDGE_B_BASE) begin
      o_slave = `BMX_SLV_BRIDGE_B;
    end else begin
      hit_raw = 1'b0;
    end
    // A slave outside this master's view counts as unmapped
    o_hit = hit_raw && SLAVE_MASK[o_slave];
  end

endmodule : bmx_decoder

// ---- verif/bmx_matrix_monitor.sv ----
module bmx_matrix_monitor (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_ext_bus_en,
  input wire logic i_sram_64k,
  input wire bmx_pkg::bmx_mreq_t [5:0] i_m_req,
  input wire bmx_pkg::bmx_rsp_t [5:0] o_m_rsp,
  input wire bmx_pkg::bmx_sreq_t [5:0] o_s_req,
  input wire bmx_pkg::bmx_rsp_t [5:0] i_s_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic any_act;
  always_comb begin
    any_act = 1'b0;
    for (int k = 0; k < 6; k++) begin
      any_act |= o_s_req[k].valid | o_m_rsp[k].done;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_fl_grant;
    o_s_req[0].valid && o_s_req[0].master == 3'h0;
  endsequence
  property p_rst; $fell(i_sys_rst) |-> !any_act; endproperty
  a_rst: assert property (p_rst) else $error("activity after reset");
  property p_fl;
    i_m_req[0].valid && i_m_req[0].addr[31:19] == 13'h1000
      |-> ##[0:30] s_fl_grant;
  endproperty
  a_fl: assert property (p_fl) else $error("flash not granted");
  property p_unm;
    $rose(i_m_req[2].valid) && i_m_req[2].addr[31:28] == 4'h9
      |=> o_m_rsp[2].done && o_m_rsp[2].err && o_m_rsp[2].rdata == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("no error answer");
  property p_src;
    o_s_req[3].valid |-> i_m_req[o_s_req[3].master].valid &&
      i_m_req[o_s_req[3].master].addr == o_s_req[3].addr;
  endproperty
  a_src: assert property (p_src) else $error("sram owner wrong");
  property p_pass;
    o_s_req[3].valid && i_s_rsp[3].done
      |-> o_m_rsp[o_s_req[3].master].done && !o_m_rsp[o_s_req[3].master].err;
  endproperty
  a_pass: assert property (p_pass) else $error("done not passed");
  property p_hold;
    o_s_req[5].valid && !i_s_rsp[5].done
      |=> o_s_req[5].valid && $stable(o_s_req[5].addr);
  endproperty
  a_hold: assert property (p_hold) else $error("ext request dropped");
  property p_ext; !i_ext_bus_en |-> !o_s_req[5].valid; endproperty
  a_ext: assert property (p_ext) else $error("ext bus when absent");
  property p_usb; o_s_req[4].valid |-> o_s_req[4].addr[31:16] == 16'he000;
  endproperty
  a_usb: assert property (p_usb) else $error("usb window wrong");
  property p_bra; o_s_req[1].valid |-> o_s_req[1].addr[31:16] == 16'hfffe;
  endproperty
  a_bra: assert property (p_bra) else $error("bridge a window");
  property p_brb; o_s_req[2].valid |-> o_s_req[2].addr[31:16] == 16'hffff;
  endproperty
  a_brb: assert property (p_brb) else $error("bridge b window");
endmodule : bmx_matrix_monitor

// ---- verif/bmx_slave_model.sv ----
module bmx_slave_model (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_stall,
  input wire bmx_pkg::bmx_sreq_t [5:0] i_s_req,
  output bmx_pkg::bmx_rsp_t [5:0] o_s_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] ack_r;
  // Answer a cycle after select; stall mimics a slow memory
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) ack_r <= 6'h00;
    else for (int k = 0; k < 6; k++)
      ack_r[k] <= i_s_req[k].valid & ~ack_r[k] & ~i_stall;
  end
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      o_s_rsp[k].done = ack_r[k] & i_s_req[k].valid;
      o_s_rsp[k].err = 1'b0;
      // Idle data is inverted so a late sample cannot match
      o_s_rsp[k].rdata = (ack_r[k] & i_s_req[k].valid) ?
        i_s_req[k].addr + 32'(k) : ~i_s_req[k].addr;
    end
  end
endmodule : bmx_slave_model

// ---- verif/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, ext = 1'b1, s64 = 1'b1, stall = 1'b0;
  bmx_pkg::bmx_mreq_t [5:0] mreq = '0;
  bmx_pkg::bmx_rsp_t [5:0] mrsp, srsp;
  bmx_pkg::bmx_sreq_t [5:0] sreq;
  int miscompares = 0, n_compared = 0;
  // addr, ext/sram64 straps, master, slave (7 = error)
  logic [39:0] rows [19] = '{
    {32'h00000000,2'h3,3'h0,3'h3}, {32'h0000fffc,2'h3,3'h1,3'h3},
    {32'h00008000,2'h2,3'h2,3'h7}, {32'h00007ffc,2'h2,3'h3,3'h3},
    {32'h80000000,2'h3,3'h0,3'h0}, {32'h8007fffc,2'h3,3'h5,3'h0},
    {32'h90000000,2'h3,3'h2,3'h7}, {32'hc0000000,2'h3,3'h0,3'h5},
    {32'hc8000000,2'h3,3'h1,3'h5}, {32'hccfffffc,2'h3,3'h2,3'h5},
    {32'hc1000000,2'h3,3'h3,3'h7}, {32'hd7fffffc,2'h3,3'h4,3'h5},
    {32'hd8000000,2'h3,3'h5,3'h7}, {32'hc0000000,2'h1,3'h0,3'h7},
    {32'hd0000000,2'h1,3'h1,3'h7}, {32'he000fffc,2'h3,3'h2,3'h4},
    {32'he0010000,2'h3,3'h3,3'h7}, {32'hfffe0000,2'h3,3'h4,3'h1},
    {32'hfffffffc,2'h3,3'h5,3'h2}};
  always #50 clk = ~clk;
  bmx_matrix DUT (.i_core_clk(clk), .i_sys_rst(rst), .i_ext_bus_en(ext),
    .i_sram_64k(s64), .i_m_req(mreq), .o_m_rsp(mrsp), .o_s_req(sreq),
    .i_s_rsp(srsp));
  bmx_slave_model u_slv (.i_core_clk(clk), .i_sys_rst(rst),
    .i_stall(stall), .i_s_req(sreq), .o_s_rsp(srsp));
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", n, exp, seen);
      miscompares++;
    end
  endtask : chk
  task automatic acc(int m, logic [31:0] a, logic [2:0] es);
    logic [2:0] got = 3'h7;
    @(negedge clk);
    mreq[m] = '{1'b1, a[2], a, ~a};
    for (int t = 0; t < 40 && mrsp[m].done !== 1'b1; t++) begin
      @(negedge clk);
      for (int k = 0; k < 6; k++) begin
        if (sreq[k].valid === 1'b1 && sreq[k].master === 3'(m)) begin
          got = 3'(k);
          chk("s_addr", sreq[k].addr, a);
          chk("s_wdata", sreq[k].wdata, ~a);
          chk("s_write", 32'(sreq[k].write), 32'(a[2]));
        end
      end
    end
    chk("done", 32'(mrsp[m].done), 32'h1);
    chk("err", 32'(mrsp[m].err), 32'(es == 3'h7));
    chk("slave", 32'(got), 32'(es));
    chk("rdata", mrsp[m].rdata, es == 3'h7 ? 32'h0 : a + 32'(es));
    @(negedge clk);
    mreq[m].valid = 1'b0;
  endtask : acc
  task automatic conclude();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    #1000000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    // -------------------------------------------------
    // Address map, every master
    // -------------------------------------------------
    foreach (rows[i]) begin
      {ext, s64} = rows[i][7:6];
      acc(int'(rows[i][5:3]), rows[i][39:8], rows[i][2:0]);
    end
    $display("test map done");
    // -------------------------------------------------
    // Two masters race for flash while it stalls
    // -------------------------------------------------
    stall = 1'b1;
    fork
      acc(1, 32'h80000010, 3'h0);
      acc(4, 32'h80000020, 3'h0);
      begin
        repeat (5) @(negedge clk);
        stall = 1'b0;
      end
    join
    $display("test contention done");
    // -------------------------------------------------
    // Reset in mid transfer
    // -------------------------------------------------
    @(negedge clk);
    stall = 1'b1;
    mreq[3] = '{1'b1, 1'b0, 32'h80000000, 32'h0};
    repeat (2) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    chk("rst_sreq", 32'(sreq[0].valid), 32'h0);
    chk("rst_done", 32'(mrsp[3].done), 32'h0);
    mreq[3].valid = 1'b0;
    stall = 1'b0;
    @(negedge clk);
    rst = 1'b0;
    acc(3, 32'h80000000, 3'h0);
    $display("test reset done");
    conclude();
  end
endmodule : tb
bind bmx_matrix bmx_matrix_monitor u_mon (.i_core_clk(i_core_clk),
  .i_sys_rst(i_sys_rst), .i_ext_bus_en(i_ext_bus_en),
  .i_sram_64k(i_sram_64k), .i_m_req(i_m_req), .o_m_rsp(o_m_rsp),
  .o_s_req(o_s_req), .i_s_rsp(i_s_rsp));
